// file: logic/csmf_framer.sv
// Purpose: Builds the cyclic current message payload and streams it to a CAN controller.
// Assumes: Fault and oscillation inputs come from other clock domains or pins and are synchronised here.
// Notes: The controller handles bit timing, stuffing, CRC and acknowledge.
`timescale 1ns/1ps

module csmf_framer
    import csmf_pkg::*;
#(
    parameter int PERIOD_CYCLES = PERIOD_CYC,
    parameter int OSC_CYCLES = OSC_LOSS_CYC,
    parameter logic [23:0] SENSOR_LABEL = 24'h5a5a01, // Arbitrary value.
    parameter logic [10:0] CAN_ID = DEFAULT_ID
) (
    input wire logic CORE_CLK, // Core clock, 50 MHz.
    input wire logic ARST_N, // Asynchronous reset, active low.
    input wire logic [31:0] MEAS_VALUE, // Signed current in mA, core domain.
    input wire logic MEAS_STROBE, // Single-cycle strobe: new measurement.
    input wire csmf_faults_s FAULT_IN, // Fault levels from monitors, async.
    input wire logic OSC_IN, // Fluxgate excitation pin, async.
    output logic TX_REQ, // Frame header valid, level until taken.
    input wire logic TX_ACK, // Controller takes header.
    output logic [10:0] TX_ID, // Standard identifier.
    output logic TX_IDE, // Extended flag, always 0.
    output logic TX_RTR, // Remote flag, always 0.
    output logic [3:0] TX_DLC, // Data length code.
    output logic BYTE_VALID, // Payload byte valid.
    input wire logic BYTE_READY, // Controller accepts byte.
    output logic [7:0] BYTE_DATA, // Payload byte.
    output logic BYTE_LAST, // Last payload byte of frame.
    output logic FAIL_ACTIVE, // Failure flag of the last frame.
    output logic [6:0] FAULT_CODE // Fault code of the last frame.
);

    localparam int PW = $clog2(PERIOD_CYCLES + 1);
    localparam int OW = $clog2(OSC_CYCLES + 1);

    typedef struct packed {
        csmf_state_e state;
        logic [PW-1:0] period_cnt;
        logic [OW-1:0] osc_cnt;
        logic osc_lost;
        logic osc_prev;
        logic fresh;
        logic [31:0] meas;
        logic [63:0] payload;
        logic [2:0] byte_idx;
        logic hdr_pending;
        logic fail;
        logic [6:0] code;
        csmf_faults_s flt_s1;
        csmf_faults_s flt_s2;
        logic osc_s1;
        logic osc_s2;
    } csmf_state_s;

    csmf_state_s st_reg;
    csmf_state_s st_next;
    csmf_byte_s fifo_in;
    csmf_byte_s fifo_out;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic overcurrent;
    logic [6:0] sel_code;
    logic [31:0] offset_value;

    // Magnitude test on the signed input; exactly 580 A in either direction still counts as normal.
    function automatic logic over_limit(input logic [31:0] v);
        logic signed [31:0] s;
        s = signed'(v);
        return (s > OVERCURRENT_MA) || (s < -OVERCURRENT_MA);
    endfunction : over_limit

    // Payload bit n maps to byte n/8; byte 0 holds bits 0..7 and goes fourth, after bytes 3, 2 and 1.
    function automatic logic [7:0] payload_byte(input logic [63:0] p, input logic [2:0] idx);
        return p[{idx, 3'h0} +: 8];
    endfunction : payload_byte

    assign overcurrent = over_limit(st_reg.meas);

    // Priority picks the most basic fault first; one code per frame.
    always_comb begin
        sel_code = FC_NONE;
        if (st_reg.flt_s2.memory) begin
            sel_code = FC_MEMORY;
        end else if (st_reg.flt_s2.clock_dev) begin
            sel_code = FC_CLOCK;
        end else if (st_reg.flt_s2.vref) begin
            sel_code = FC_VREF;
        end else if (st_reg.flt_s2.supply) begin
            sel_code = FC_SUPPLY;
        end else if (st_reg.flt_s2.adc) begin
            sel_code = FC_ADC;
        end else if (st_reg.flt_s2.dac) begin
            sel_code = FC_DAC;
        end else if (st_reg.osc_lost) begin
            sel_code = FC_OSC_LOSS;
        end else if (!st_reg.fresh) begin
            sel_code = FC_STALE;
        end else if (overcurrent) begin
            sel_code = FC_OVERCURRENT;
        end
    end

    // Signed mA to offset binary is a flip of the top bit.
    assign offset_value = st_reg.meas ^ CURRENT_ZERO;

    // Main sequencing, synchronisers and monitors.
    always_comb begin
        st_next = st_reg;
        st_next.flt_s1 = FAULT_IN;
        st_next.flt_s2 = st_reg.flt_s1;
        st_next.osc_s1 = OSC_IN;
        st_next.osc_s2 = st_reg.osc_s1;
        st_next.osc_prev = st_reg.osc_s2;
        // Any edge of the excitation restarts the watchdog.
        if (st_reg.osc_s2 != st_reg.osc_prev) begin
            st_next.osc_cnt = '0;
            st_next.osc_lost = 1'b0;
        end else if (st_reg.osc_cnt >= OW'(OSC_CYCLES)) begin
            st_next.osc_lost = 1'b1;
        end else begin
            st_next.osc_cnt = st_reg.osc_cnt + 1'b1;
        end
        if (MEAS_STROBE) begin
            st_next.meas = MEAS_VALUE;
            st_next.fresh = 1'b1;
        end
        // Free-running period; a frame still pushing or a header not yet taken at the tick makes the next frame wait for the following tick.
        if (st_reg.period_cnt >= PW'(PERIOD_CYCLES - 1)) begin
            st_next.period_cnt = '0;
        end else begin
            st_next.period_cnt = st_reg.period_cnt + 1'b1;
        end
        if (TX_ACK) begin
            st_next.hdr_pending = 1'b0;
        end
        case (st_reg.state)
            ST_IDLE: begin
                if (st_reg.period_cnt >= PW'(PERIOD_CYCLES - 1) && !st_reg.hdr_pending) begin
                    st_next.state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                st_next.fail = (sel_code != FC_NONE);
                st_next.code = sel_code;
                st_next.payload[31:0] = (sel_code != FC_NONE) ? CURRENT_FAIL : offset_value;
                st_next.payload[32] = (sel_code != FC_NONE);
                st_next.payload[39:33] = sel_code;
                st_next.payload[63:40] = SENSOR_LABEL;
                // A strobe in this cycle counts for the next frame, not this one.
                st_next.fresh = MEAS_STROBE;
                st_next.byte_idx = '0;
                st_next.hdr_pending = 1'b1;
                st_next.state = ST_PUSH;
            end
            ST_PUSH: begin
                if (fifo_in_ready) begin
                    st_next.byte_idx = st_reg.byte_idx + 1'b1;
                    if (st_reg.byte_idx == 3'(PAYLOAD_BYTES - 1)) begin
                        st_next.state = ST_IDLE;
                    end
                end
            end
            default: begin
                st_next.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Bytes are reordered so each multi-byte signal leaves high byte first.
    always_comb begin
        fifo_in.last = (st_reg.byte_idx == 3'(PAYLOAD_BYTES - 1));
        case (st_reg.byte_idx)
            3'h0: fifo_in.data = payload_byte(st_reg.payload, 3'h3);
            3'h1: fifo_in.data = payload_byte(st_reg.payload, 3'h2);
            3'h2: fifo_in.data = payload_byte(st_reg.payload, 3'h1);
            3'h3: fifo_in.data = payload_byte(st_reg.payload, 3'h0);
            3'h4: fifo_in.data = payload_byte(st_reg.payload, 3'h4);
            3'h5: fifo_in.data = payload_byte(st_reg.payload, 3'h7);
            3'h6: fifo_in.data = payload_byte(st_reg.payload, 3'h6);
            default: fifo_in.data = payload_byte(st_reg.payload, 3'h5);
        endcase
    end

    assign fifo_in_valid = (st_reg.state == ST_PUSH);

    csmf_fifo #(.WIDTH($bits(csmf_byte_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(BYTE_READY),
        .out_data(fifo_out)
    );

    // Header fields are constant apart from the request level.
    assign TX_REQ = st_reg.hdr_pending;
    assign TX_ID = CAN_ID;
    assign TX_IDE = 1'b0;
    assign TX_RTR = 1'b0;
    assign TX_DLC = DLC_VALUE;
    assign BYTE_VALID = fifo_out_valid;
    assign BYTE_DATA = fifo_out.data;
    assign BYTE_LAST = fifo_out.last;
    assign FAIL_ACTIVE = st_reg.fail;
    assign FAULT_CODE = st_reg.code;

endmodule : csmf_framer

// file: common/csmf_pkg.sv
// Purpose: Shared constants and types for the current sensor message framer.
// Assumes: 50 MHz core clock, payload of eight bytes sent over a byte stream.
// Notes: Fault codes and the payload length are collected here once; the framer sets the payload layout.
package csmf_pkg;

    localparam int CLK_HZ = 50000000;
    localparam int PERIOD_MS = 10;
    localparam int PERIOD_CYC = PERIOD_MS * (CLK_HZ / 1000);
    localparam int OSC_LOSS_MS = 20;
    localparam int OSC_LOSS_CYC = OSC_LOSS_MS * (CLK_HZ / 1000);
    localparam int OVERCURRENT_MA = 580000;
    localparam logic [31:0] CURRENT_ZERO = 32'h80000000;
    localparam logic [31:0] CURRENT_FAIL = 32'hffffffff;
    localparam logic [6:0] FC_NONE = 7'h00;
    localparam logic [6:0] FC_MEMORY = 7'h40;
    localparam logic [6:0] FC_OVERCURRENT = 7'h41;
    localparam logic [6:0] FC_OSC_LOSS = 7'h42;
    localparam logic [6:0] FC_CLOCK = 7'h44;
    localparam logic [6:0] FC_SUPPLY = 7'h46;
    localparam logic [6:0] FC_ADC = 7'h47;
    localparam logic [6:0] FC_STALE = 7'h49;
    localparam logic [6:0] FC_DAC = 7'h4a;
    localparam logic [6:0] FC_VREF = 7'h4b;
    localparam int PAYLOAD_BYTES = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [10:0] DEFAULT_ID = 11'h3c2;
    localparam logic [3:0] DLC_VALUE = 4'h8;

    // Failure inputs gathered in one carrier.
    typedef struct packed {
        logic memory;
        logic clock_dev;
        logic supply;
        logic adc;
        logic dac;
        logic vref;
    } csmf_faults_s;

    // One payload byte on its way to the controller, with a frame end marker.
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } csmf_byte_s;

    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_PUSH} csmf_state_e;

endpackage : csmf_pkg

// file: logic/csmf_mem.sv
// Purpose: Small register-output memory holding the FIFO words.
// Assumes: One write and one read port on the same clock.
// Notes: Read data is registered, so it appears one cycle after the address.
`timescale 1ns/1ps
module csmf_mem #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk, // Core clock.
    input wire logic wr_en, // Write strobe.
    input wire logic [AW-1:0] wr_addr, // Write address.
    input wire logic [WIDTH-1:0] wr_data, // Write data.
    input wire logic [AW-1:0] rd_addr, // Read address.
    output logic [WIDTH-1:0] rd_data // Registered read data.
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Storage is left without reset; the FIFO never reads an unwritten slot.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule : csmf_mem

// file: logic/csmf_fifo.sv
// Purpose: Valid/ready FIFO buffering payload bytes toward the CAN controller.
// Assumes: Depth is a power of two.
// Notes: A one-word output register hides the memory read latency.
`timescale 1ns/1ps
module csmf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk, // Core clock.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic in_valid, // Write request.
    output logic in_ready, // Space available.
    input wire logic [WIDTH-1:0] in_data, // Write data.
    output logic out_valid, // Output word present.
    input wire logic out_ready, // Consumer takes the word.
    output logic [WIDTH-1:0] out_data // Output word.
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
        logic pending;
        logic out_valid;
    } csmf_fifo_state_s;

    csmf_fifo_state_s st_reg;
    csmf_fifo_state_s st_next;
    logic [WIDTH-1:0] rd_data;
    logic [WIDTH-1:0] out_data_reg;
    logic do_wr;
    logic do_rd;
    logic empty;
    logic full;

    // The pending word counts as occupied so full stays honest.
    assign empty = (st_reg.wr_ptr == st_reg.rd_ptr);
    assign full = (st_reg.wr_ptr[AW] != st_reg.rd_ptr[AW]) && (st_reg.wr_ptr[AW-1:0] == st_reg.rd_ptr[AW-1:0]);
    assign in_ready = !full;
    assign do_wr = in_valid && !full;
    assign do_rd = !empty && !st_reg.pending && (!st_reg.out_valid || out_ready);
    assign out_valid = st_reg.out_valid;
    assign out_data = out_data_reg;

    csmf_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
        .clk(clk),
        .wr_en(do_wr),
        .wr_addr(st_reg.wr_ptr[AW-1:0]),
        .wr_data(in_data),
        .rd_addr(st_reg.rd_ptr[AW-1:0]),
        .rd_data(rd_data)
    );

    // Pointer and output register bookkeeping.
    always_comb begin
        st_next = st_reg;
        if (do_wr) begin
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
        end
        if (st_reg.out_valid && out_ready) begin
            st_next.out_valid = 1'b0;
        end
        if (st_reg.pending) begin
            st_next.out_valid = 1'b1;
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        end
        st_next.pending = do_rd;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Capture the memory word when it arrives.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_data_reg <= '0;
        end else if (st_reg.pending) begin
            out_data_reg <= rd_data;
        end
    end

endmodule : csmf_fifo

// file: sim/csmf_framer_checker.sv
// Purpose: Concurrent checks on the message framer ports.
// Assumes: The far side takes each header well within one period.
// Notes: Bound into every framer instance.
`timescale 1ns/1ps
module csmf_framer_checker
    import csmf_pkg::*;
#(
    parameter int PERIOD_CYCLES = PERIOD_CYC,
    parameter logic [10:0] CAN_ID = DEFAULT_ID
) (
    input wire logic CORE_CLK, // Core clock.
    input wire logic ARST_N, // Reset, active low.
    input wire csmf_faults_s FAULT_IN, // Fault levels.
    input wire logic TX_REQ, // Header valid.
    input wire logic TX_ACK, // Header taken.
    input wire logic [10:0] TX_ID, // Identifier.
    input wire logic TX_IDE, // Extended flag.
    input wire logic TX_RTR, // Remote flag.
    input wire logic [3:0] TX_DLC, // Length code.
    input wire logic BYTE_VALID, // Byte valid.
    input wire logic BYTE_READY, // Byte accepted.
    input wire logic [7:0] BYTE_DATA, // Payload byte.
    input wire logic BYTE_LAST, // Last byte.
    input wire logic FAIL_ACTIVE, // Failure flag.
    input wire logic [6:0] FAULT_CODE // Fault code.
);
    logic req_reg;
    logic seen_reg;
    logic [2:0] bcnt_reg;
    int gap_reg;
    logic rise;

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);

    // A header rise is the start of a frame.
    assign rise = TX_REQ && !req_reg;

    // Gap between header rises and byte position; a retried header would double the gap.
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            req_reg <= 1'b0;
            seen_reg <= 1'b0;
            bcnt_reg <= 3'h0;
            gap_reg <= 0;
        end else begin
            req_reg <= TX_REQ;
            seen_reg <= seen_reg || rise;
            gap_reg <= rise ? 1 : gap_reg + 1;
            if (BYTE_VALID && BYTE_READY) begin
                bcnt_reg <= bcnt_reg + 3'h1;
            end
        end
    end

    a_header_fixed: assert property (TX_REQ |->
        TX_ID == CAN_ID && !TX_IDE && !TX_RTR && TX_DLC == DLC_VALUE)
        else $error("header fields wrong");
    a_req_holds: assert property (TX_REQ && !TX_ACK |=> TX_REQ)
        else $error("header request dropped early");
    a_req_drops: assert property (TX_REQ && TX_ACK |=> !TX_REQ)
        else $error("header request kept after ack");
    a_byte_holds: assert property (BYTE_VALID && !BYTE_READY |=>
        BYTE_VALID && $stable(BYTE_DATA) && $stable(BYTE_LAST))
        else $error("byte changed while stalled");
    a_last_eighth: assert property (BYTE_VALID && BYTE_READY |-> BYTE_LAST == (bcnt_reg == 3'h7))
        else $error("last marker misplaced");
    a_flag_code: assert property (FAIL_ACTIVE == (FAULT_CODE != FC_NONE))
        else $error("flag and code disagree");
    a_code_known: assert property (FAIL_ACTIVE |->
        FAULT_CODE inside {7'h40, 7'h41, 7'h42, 7'h44, 7'h46, 7'h47, 7'h49, 7'h4a, 7'h4b})
        else $error("unknown fault code");
    a_memory_wins: assert property (FAULT_IN.memory [*8] ##1 rise |-> ##[0:1] FAULT_CODE == FC_MEMORY)
        else $error("memory fault not reported");
    a_clock_dev: assert property ((FAULT_IN.clock_dev && !FAULT_IN.memory) [*8] ##1 rise |->
        ##[0:1] FAULT_CODE == FC_CLOCK)
        else $error("clock fault not reported");
    a_period_gap: assert property (rise && seen_reg |-> gap_reg == PERIOD_CYCLES)
        else $error("frame period wrong");
endmodule : csmf_framer_checker

bind csmf_framer csmf_framer_checker #(.PERIOD_CYCLES(PERIOD_CYCLES), .CAN_ID(CAN_ID)) i_csmf_framer_checker (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .FAULT_IN(FAULT_IN), .TX_REQ(TX_REQ), .TX_ACK(TX_ACK),
    .TX_ID(TX_ID), .TX_IDE(TX_IDE), .TX_RTR(TX_RTR), .TX_DLC(TX_DLC), .BYTE_VALID(BYTE_VALID),
    .BYTE_READY(BYTE_READY), .BYTE_DATA(BYTE_DATA), .BYTE_LAST(BYTE_LAST), .FAIL_ACTIVE(FAIL_ACTIVE),
    .FAULT_CODE(FAULT_CODE)
);

// file: sim/csmf_can_model.sv
// Purpose: Behavioural CAN controller taking headers and payload bytes.
// Assumes: Its ack and ready outputs change on the falling clock edge; rx_frame and rx_done on the rising edge.
// Notes: Random ack delay and byte stalls model a busy controller.
`timescale 1ns/1ps
module csmf_can_model (
    input wire logic clk, // Core clock.
    input wire logic arst_n, // Reset, active low.
    input wire logic tx_req, // Header valid.
    output logic tx_ack, // Header taken.
    input wire logic byte_valid, // Byte valid.
    output logic byte_ready, // Byte accepted.
    input wire logic [7:0] byte_data, // Payload byte.
    output logic [63:0] rx_frame, // Last payload, first byte on top.
    output logic rx_done // High for one cycle per payload.
);
    int seed = 32'h1d3;
    logic [31:0] rnd;
    logic [2:0] cnt;

    // Ack lasts one cycle so a taken header is never taken twice.
    always @(negedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_ack <= 1'b0;
            byte_ready <= 1'b0;
        end else begin
            rnd = $random(seed);
            tx_ack <= tx_req && !tx_ack && rnd[2:1] == 2'b00;
            byte_ready <= rnd[0];
        end
    end

    // Bytes gather first on top; the eighth closes the payload.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 3'h0;
            rx_done <= 1'b0;
            rx_frame <= 64'h0;
        end else begin
            rx_done <= 1'b0;
            if (byte_valid && byte_ready) begin
                rx_frame <= {rx_frame[55:0], byte_data};
                cnt <= cnt + 3'h1;
                rx_done <= cnt == 3'h7;
            end
        end
    end
endmodule : csmf_can_model

// file: sim/testbench.sv
// Purpose: Self-checking bench for the current message framer.
// Assumes: Short period and oscillation counts keep the run brief.
// Notes: Each frame is predicted from inputs set after the previous one.
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin compares++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); end end
module testbench
    import csmf_pkg::*;
;
    localparam int PER = 200;
    localparam logic [23:0] LABEL = 24'h3a7e11; // Arbitrary value.
    localparam logic [10:0] ID = 11'h2b5;
    logic CORE_CLK = 1'b0, ARST_N = 1'b0, MEAS_STROBE = 1'b0, OSC_IN = 1'b0, osc_en = 1'b1;
    logic [31:0] MEAS_VALUE = 32'h0, cur;
    csmf_faults_s FAULT_IN = '0;
    logic TX_REQ, TX_ACK, TX_IDE, TX_RTR, BYTE_VALID, BYTE_READY, BYTE_LAST, FAIL_ACTIVE, rx_done;
    logic [10:0] TX_ID;
    logic [3:0] TX_DLC;
    logic [7:0] BYTE_DATA;
    logic [6:0] FAULT_CODE;
    logic [63:0] rx_frame;
    logic [31:0] r;
    int errors = 0, compares = 0, seed = 32'ha52f;
    logic [31:0] corner [8] = '{32'h0, 32'h0008d9a0, 32'hfff72660, 32'h0008d9a1, 32'hfff7265f,
        32'h1, 32'hffffffff, 32'h7fffffff};

    csmf_framer #(.PERIOD_CYCLES(PER), .OSC_CYCLES(50), .SENSOR_LABEL(LABEL), .CAN_ID(ID)) i_csmf_framer (
        .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .MEAS_VALUE(MEAS_VALUE), .MEAS_STROBE(MEAS_STROBE),
        .FAULT_IN(FAULT_IN), .OSC_IN(OSC_IN), .TX_REQ(TX_REQ), .TX_ACK(TX_ACK), .TX_ID(TX_ID), .TX_IDE(TX_IDE),
        .TX_RTR(TX_RTR), .TX_DLC(TX_DLC), .BYTE_VALID(BYTE_VALID), .BYTE_READY(BYTE_READY),
        .BYTE_DATA(BYTE_DATA), .BYTE_LAST(BYTE_LAST), .FAIL_ACTIVE(FAIL_ACTIVE), .FAULT_CODE(FAULT_CODE));
    csmf_can_model i_csmf_can_model (.clk(CORE_CLK), .arst_n(ARST_N), .tx_req(TX_REQ), .tx_ack(TX_ACK),
        .byte_valid(BYTE_VALID), .byte_ready(BYTE_READY), .byte_data(BYTE_DATA), .rx_frame(rx_frame),
        .rx_done(rx_done));

    // Clock of 50 MHz.
    always #10 CORE_CLK = ~CORE_CLK;

    // Excitation toggles every cycle unless a scenario kills it.
    always @(negedge CORE_CLK) if (osc_en) OSC_IN <= ~OSC_IN;

    // Payload as the controller should see it, highest priority fault first.
    function automatic logic [63:0] expect_frame(logic [31:0] v, logic fresh, csmf_faults_s f, logic dead);
        logic [6:0] c;
        logic [31:0] mag;
        mag = v[31] ? -v : v;
        if (f.memory) c = FC_MEMORY;
        else if (f.clock_dev) c = FC_CLOCK;
        else if (f.vref) c = FC_VREF;
        else if (f.supply) c = FC_SUPPLY;
        else if (f.adc) c = FC_ADC;
        else if (f.dac) c = FC_DAC;
        else if (dead) c = FC_OSC_LOSS;
        else if (!fresh) c = FC_STALE;
        else if (mag > OVERCURRENT_MA) c = FC_OVERCURRENT;
        else c = FC_NONE;
        return {(c != FC_NONE) ? CURRENT_FAIL : v ^ CURRENT_ZERO, c, c != FC_NONE, LABEL};
    endfunction : expect_frame

    // Sets the inputs for the next frame, waits for it and compares it.
    task automatic run_frame(input logic [31:0] v, input logic fresh, input csmf_faults_s f, input logic dead);
        logic [63:0] exp;
        int n;
        exp = expect_frame(v, fresh, f, dead);
        FAULT_IN = f;
        osc_en = !dead;
        MEAS_VALUE = fresh ? v : MEAS_VALUE;
        MEAS_STROBE = fresh;
        @(negedge CORE_CLK);
        MEAS_STROBE = 1'b0;
        n = 0;
        while (rx_done !== 1'b1 && n < 2 * PER) begin
            @(negedge CORE_CLK);
            n++;
        end
        // A frame that never arrives must fail here, not compare against the previous payload.
        `CHECK("frame done", 1'b1, rx_done)
        `CHECK("payload", exp, rx_frame)
        `CHECK("flag", exp[24], FAIL_ACTIVE)
        `CHECK("code", exp[31:25], FAULT_CODE)
    endtask : run_frame

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // Corner cases first, then random traffic, then a reset in mid-run.
    initial begin
        repeat (16) @(negedge CORE_CLK);
        ARST_N = 1'b1;
        run_frame(32'h0, 1'b0, '0, 1'b0);
        foreach (corner[i]) run_frame(corner[i], 1'b1, '0, 1'b0);
        for (int i = 0; i < 6; i++) begin
            run_frame(32'h1234, 1'b1, 6'h20 >> i, 1'b0);
        end
        run_frame(32'h10, 1'b1, csmf_faults_s'(6'h0f), 1'b0);
        run_frame(32'h10, 1'b1, csmf_faults_s'(6'h06), 1'b0);
        run_frame(32'h10, 1'b1, csmf_faults_s'(6'h02), 1'b1);
        run_frame(32'h10, 1'b0, '0, 1'b1);
        run_frame(32'h0008d9a1, 1'b0, '0, 1'b0);
        for (int i = 0; i < 20; i++) begin
            cur = 32'($random(seed) % 700000);
            r = $random(seed);
            run_frame(cur, r[8:7] != 2'b00, (r[3:0] == 4'h0) ? 6'h01 << r[6:4] : 6'h00,
                r[12:9] == 4'h0);
        end
        ARST_N = 1'b0;
        @(negedge CORE_CLK);
        `CHECK("reset outputs", 10'h000, {TX_REQ, BYTE_VALID, FAIL_ACTIVE, FAULT_CODE})
        `CHECK("reset header", {ID, 4'h8}, {TX_ID, TX_DLC})
        repeat (3) @(negedge CORE_CLK);
        ARST_N = 1'b1;
        run_frame(32'h0, 1'b0, '0, 1'b0);
        run_frame(32'hffffff00, 1'b1, '0, 1'b0);
        summarize();
    end

    // Guard against a hang: about twice the expected run.
    initial begin
        repeat (50 * 2 * PER) @(negedge CORE_CLK);
        errors++;
        summarize();
    end
endmodule : testbench
